// ---- include/pcpm_params.svh ----
/*
 * Constants of the power controller pin function multiplexer.
 * Assumes: included by bare name after the package; definitions only.
 */
`ifndef PCPM_PARAMS_SVH
`define PCPM_PARAMS_SVH

// ************************************************************
// Widths
// ************************************************************
`define PCPM_PORT_W 8
`define PCPM_MODE_W 3

// ************************************************************
// Phase mode field codes
// ************************************************************
`define PCPM_MODE_STANDALONE 3'h0
`define PCPM_MODE_MO_MASTER 3'h1
`define PCPM_MODE_MO_SLAVE 3'h2
`define PCPM_MODE_MP_MASTER 3'h3
`define PCPM_MODE_MP_SLAVE 3'h4

// ************************************************************
// Pin positions
// ************************************************************
`define PCPM_A_ANTEST 0
`define PCPM_A_SYNC 1
`define PCPM_A_TMR 2
`define PCPM_A_ANALOG_TOP 3
`define PCPM_A_PDAT 6
`define PCPM_A_SCL 7
`define PCPM_B_SDA 0
`define PCPM_B_EAMP 1
`define PCPM_B_AN5 2
`define PCPM_B_PDAT 4
`define PCPM_B_ALTSYNC 5
`define PCPM_BIT_M(b) (8'h01 << (b))

// ************************************************************
// Pin capability masks
// ************************************************************
`define PCPM_A_ANALOG_MASK 8'h0F
`define PCPM_A_OD_MASK 8'h90
`define PCPM_A_INONLY_MASK 8'h20
`define PCPM_A_PULLUP_MASK 8'h2F
`define PCPM_B_ANALOG_MASK 8'h36
`define PCPM_B_OD_MASK 8'h01
`define PCPM_B_PULLUP_MASK 8'hF6
`define PCPM_B_SMALL_MASK 8'h07
`define PCPM_B_LARGE_MASK 8'hF7

// ************************************************************
// Reset values
// ************************************************************
`define PCPM_RST_BYTE 8'h00
`define PCPM_RST_BIT 1'b0
`define PCPM_RST_SYNC 2'h0

`endif

// ---- include/pcpm_pkg.sv ----
/*
 * Types of the power controller pin function multiplexer.
 * Assumes: compiled before every other file of the block.
 */
package pcpm_pkg;

  typedef enum logic [4:0] {
    PCPM_ROLE_NONE = 5'h01,
    PCPM_ROLE_MO_MASTER = 5'h02,
    PCPM_ROLE_MO_SLAVE = 5'h04,
    PCPM_ROLE_MP_MASTER = 5'h08,
    PCPM_ROLE_MP_SLAVE = 5'h10
  } pcpm_role_type;

endpackage : pcpm_pkg

// ---- include/pcpm_role_if.sv ----
/*
 * Carries the phase mode and the decoded system role inside the block.
 * Assumes: pcpm_pkg compiled first.
 */
`timescale 1ns/1ps
interface pcpm_role_if;
  import pcpm_pkg::*;
  logic [2:0] phase_mode;
  pcpm_role_type role;
  logic sync_active;
  logic sync_master;
  logic eamp_active;
  modport dec (input phase_mode, output role, output sync_active, output sync_master,
    output eamp_active);
  modport user (output phase_mode, input role, input sync_active, input sync_master,
    input eamp_active);
endinterface : pcpm_role_if

// ---- hw/pcpm_phase_decode.sv ----
/*
 * Decodes the phase mode field into the multiple-output or multi-phase role.
 * Assumes: field is a level from the core clock domain.
 */
`timescale 1ns/1ps
`include "pcpm_params.svh"
module pcpm_phase_decode
  import pcpm_pkg::*;
(
  pcpm_role_if.dec rif
);

  wire is_mo_master = (rif.phase_mode == `PCPM_MODE_MO_MASTER);
  wire is_mo_slave = (rif.phase_mode == `PCPM_MODE_MO_SLAVE);
  wire is_mp_master = (rif.phase_mode == `PCPM_MODE_MP_MASTER);
  wire is_mp_slave = (rif.phase_mode == `PCPM_MODE_MP_SLAVE);

  // Unused codes fall back to standalone
  assign rif.role = is_mo_master ? PCPM_ROLE_MO_MASTER :
                    is_mo_slave ? PCPM_ROLE_MO_SLAVE :
                    is_mp_master ? PCPM_ROLE_MP_MASTER :
                    is_mp_slave ? PCPM_ROLE_MP_SLAVE : PCPM_ROLE_NONE;
  assign rif.sync_active = is_mo_master | is_mo_slave | is_mp_master | is_mp_slave;
  assign rif.sync_master = is_mo_master | is_mp_master;
  assign rif.eamp_active = rif.sync_active;

endmodule : pcpm_phase_decode

// ---- hw/pcpm_change_detect.sv ----
/*
 * Interrupt-on-change detector, one cell per pin.
 * Assumes: pin levels synchronous to sys_clk; rst_n already synchronised.
 */
`timescale 1ns/1ps
`include "pcpm_params.svh"
module pcpm_change_detect (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] pin_level,
  input wire logic [7:0] enable,
  output logic [7:0] change_pulse
);

  logic [7:0] prev_reg;
  logic [7:0] pulse_reg;

  genvar i;
  generate
    for (i = 0; i < `PCPM_PORT_W; i = i + 1) begin : g_cell
      wire pulse_next = enable[i] & (pin_level[i] ^ prev_reg[i]);
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          prev_reg[i] <= `PCPM_RST_BIT;
          pulse_reg[i] <= `PCPM_RST_BIT;
        end else begin
          prev_reg[i] <= pin_level[i];
          pulse_reg[i] <= pulse_next;
        end
      end
    end
  endgenerate

  assign change_pulse = pulse_reg;

endmodule : pcpm_change_detect

// ---- hw/pcpm_pin_mux.sv ----
/*
 * Pin function multiplexer of a power controller: ports A and B, analog
 * routing, synchronisation, error amplifier, timer, interrupt, I2C and
 * serial programming pins.
 * Assumes: pad inputs synchronous to sys_clk; pad ring resolves the wire
 * from out and oe; direction bit 1 means input.
 */
`timescale 1ns/1ps
`include "pcpm_params.svh"
module pcpm_pin_mux
  import pcpm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic large_package,
  input wire logic [7:0] port_a_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe,
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe,
  input wire logic [7:0] port_a_direction_reg,
  input wire logic [7:0] port_b_direction_reg,
  input wire logic [7:0] port_a_latch,
  input wire logic [7:0] port_b_latch,
  input wire logic [7:0] port_a_analog_select_bit,
  input wire logic [7:0] port_b_analog_select_bit,
  input wire logic [7:0] port_a_pullup_select,
  input wire logic [7:0] port_b_pullup_select,
  input wire logic [7:0] port_a_ioc_enable,
  input wire logic [7:0] port_b_ioc_enable,
  input wire logic analog_test_enable,
  input wire logic [2:0] phase_mode_field,
  input wire logic alt_sync_select,
  input wire logic timer_zero_source_select,
  input wire logic external_interrupt_enable,
  input wire logic i2c_enable,
  input wire logic i2c_scl_drive_low,
  input wire logic i2c_sda_drive_low,
  input wire logic sync_clock_out,
  input wire logic program_mode,
  input wire logic program_data_out,
  input wire logic program_data_oe,
  output logic [7:0] port_a_value,
  output logic [7:0] port_b_value,
  output logic [7:0] port_a_pullup_on,
  output logic [7:0] port_b_pullup_on,
  output logic [7:0] port_a_change,
  output logic [7:0] port_b_change,
  output logic [7:0] adc_channel_connect,
  output logic analog_test_out_on,
  output logic error_amp_connect,
  output logic sync_master_on,
  output logic sync_clock_in,
  output logic timer_zero_ext_clock,
  output logic external_interrupt_in,
  output logic i2c_scl_in,
  output logic i2c_sda_in,
  output logic serial_program_clock,
  output logic serial_program_data_in
);

  // ************************************************************
  // Reset release
  // ************************************************************
  logic [1:0] rst_sync_reg;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= `PCPM_RST_SYNC;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  wire rst_n = rst_sync_reg[1];

  // ************************************************************
  // Role decode
  // ************************************************************
  pcpm_role_if rif ();
  assign rif.phase_mode = phase_mode_field;
  pcpm_phase_decode u_decode (
    .rif(rif)
  );

  // ************************************************************
  // Package and mode qualifiers
  // ************************************************************
  wire [7:0] b_exist = large_package ? `PCPM_B_LARGE_MASK : `PCPM_B_SMALL_MASK;
  wire prog_small = program_mode & ~large_package;
  wire prog_large = program_mode & large_package;
  wire alt_sync = large_package & alt_sync_select & ~prog_large;
  wire sync_on_a = rif.sync_active & ~alt_sync;
  wire sync_on_b = rif.sync_active & alt_sync;
  wire sync_drive_a = sync_on_a & rif.sync_master;
  wire sync_drive_b = sync_on_b & rif.sync_master;
  wire i2c_scl_own = i2c_enable & ~prog_small;

  // ************************************************************
  // Analog routing
  // ************************************************************
  wire [7:0] a_analog = port_a_direction_reg & port_a_analog_select_bit &
                        `PCPM_A_ANALOG_MASK;
  wire [7:0] b_analog = port_b_direction_reg & port_b_analog_select_bit &
                        `PCPM_B_ANALOG_MASK & b_exist;
  wire [7:0] adc_next = {b_analog[`PCPM_B_ALTSYNC], b_analog[`PCPM_B_PDAT],
                         b_analog[`PCPM_B_AN5], b_analog[`PCPM_B_EAMP],
                         a_analog[`PCPM_A_ANALOG_TOP:0]};

  // ************************************************************
  // General purpose drive
  // ************************************************************
  // Open drain drives low only
  wire [7:0] a_gen_oe = ~port_a_direction_reg & ~`PCPM_A_INONLY_MASK &
                        ~(port_a_latch & `PCPM_A_OD_MASK);
  wire [7:0] a_gen_out = port_a_latch & ~`PCPM_A_OD_MASK;
  wire [7:0] b_gen_oe = ~port_b_direction_reg & b_exist &
                        ~(port_b_latch & `PCPM_B_OD_MASK);
  wire [7:0] b_gen_out = port_b_latch & ~`PCPM_B_OD_MASK & b_exist;

  // ************************************************************
  // Peripheral ownership, port A
  // ************************************************************
  wire [7:0] a_own_m =
    (analog_test_enable ? `PCPM_BIT_M(`PCPM_A_ANTEST) : 8'h00) |
    (sync_on_a ? `PCPM_BIT_M(`PCPM_A_SYNC) : 8'h00) |
    (prog_small ? (`PCPM_BIT_M(`PCPM_A_PDAT) | `PCPM_BIT_M(`PCPM_A_SCL)) : 8'h00) |
    (i2c_scl_own ? `PCPM_BIT_M(`PCPM_A_SCL) : 8'h00);
  wire [7:0] a_own_oe =
    (sync_drive_a ? `PCPM_BIT_M(`PCPM_A_SYNC) : 8'h00) |
    ((prog_small & program_data_oe) ? `PCPM_BIT_M(`PCPM_A_PDAT) : 8'h00) |
    ((i2c_scl_own & i2c_scl_drive_low) ? `PCPM_BIT_M(`PCPM_A_SCL) : 8'h00);
  wire [7:0] a_own_out =
    ((sync_drive_a & sync_clock_out) ? `PCPM_BIT_M(`PCPM_A_SYNC) : 8'h00) |
    ((prog_small & program_data_out) ? `PCPM_BIT_M(`PCPM_A_PDAT) : 8'h00);

  // ************************************************************
  // Peripheral ownership, port B
  // ************************************************************
  wire [7:0] b_own_m =
    (i2c_enable ? `PCPM_BIT_M(`PCPM_B_SDA) : 8'h00) |
    (rif.eamp_active ? `PCPM_BIT_M(`PCPM_B_EAMP) : 8'h00) |
    (prog_large ? (`PCPM_BIT_M(`PCPM_B_PDAT) | `PCPM_BIT_M(`PCPM_B_ALTSYNC)) : 8'h00) |
    (sync_on_b ? `PCPM_BIT_M(`PCPM_B_ALTSYNC) : 8'h00);
  wire [7:0] b_own_oe =
    ((i2c_enable & i2c_sda_drive_low) ? `PCPM_BIT_M(`PCPM_B_SDA) : 8'h00) |
    ((prog_large & program_data_oe) ? `PCPM_BIT_M(`PCPM_B_PDAT) : 8'h00) |
    (sync_drive_b ? `PCPM_BIT_M(`PCPM_B_ALTSYNC) : 8'h00);
  wire [7:0] b_own_out =
    ((prog_large & program_data_out) ? `PCPM_BIT_M(`PCPM_B_PDAT) : 8'h00) |
    ((sync_drive_b & sync_clock_out) ? `PCPM_BIT_M(`PCPM_B_ALTSYNC) : 8'h00);

  // ************************************************************
  // Final pad selection
  // ************************************************************
  wire [7:0] a_oe_next = (a_own_m & a_own_oe) | (~a_own_m & a_gen_oe);
  wire [7:0] a_out_next = (a_own_m & a_own_out) | (~a_own_m & a_gen_out);
  wire [7:0] b_oe_next = (b_own_m & b_own_oe) | (~b_own_m & b_gen_oe);
  wire [7:0] b_out_next = (b_own_m & b_own_out) | (~b_own_m & b_gen_out);

  // ************************************************************
  // Digital inputs, pull-ups, change enables
  // ************************************************************
  // Analog pins read as zero
  wire [7:0] a_value_next = port_a_in & ~a_analog;
  wire [7:0] b_value_next = port_b_in & ~b_analog & b_exist;
  wire [7:0] a_pull_next = port_a_pullup_select & `PCPM_A_PULLUP_MASK &
                           port_a_direction_reg & ~a_analog;
  wire [7:0] b_pull_next = port_b_pullup_select & `PCPM_B_PULLUP_MASK &
                           port_b_direction_reg & ~b_analog & b_exist;
  wire [7:0] a_ioc_en = port_a_ioc_enable & ~a_analog;
  wire [7:0] b_ioc_en = port_b_ioc_enable & ~b_analog & b_exist;

  // ************************************************************
  // Peripheral inputs
  // ************************************************************
  wire sync_in_next = rif.sync_active & ~rif.sync_master &
                      (alt_sync ? port_b_in[`PCPM_B_ALTSYNC] :
                      port_a_in[`PCPM_A_SYNC]);
  wire tmr_next = timer_zero_source_select & port_a_in[`PCPM_A_TMR];
  wire int_next = external_interrupt_enable & port_a_in[`PCPM_A_TMR];
  wire scl_next = i2c_scl_own & port_a_in[`PCPM_A_SCL];
  wire sda_next = i2c_enable & port_b_in[`PCPM_B_SDA];
  wire pclk_next = large_package ? (prog_large & port_b_in[`PCPM_B_ALTSYNC]) :
                   (prog_small & port_a_in[`PCPM_A_SCL]);
  wire pdat_next = large_package ? (prog_large & port_b_in[`PCPM_B_PDAT]) :
                   (prog_small & port_a_in[`PCPM_A_PDAT]);

  // ************************************************************
  // Change detection
  // ************************************************************
  pcpm_change_detect u_change_a (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_level(port_a_in),
    .enable(a_ioc_en),
    .change_pulse(port_a_change)
  );

  pcpm_change_detect u_change_b (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_level(port_b_in),
    .enable(b_ioc_en),
    .change_pulse(port_b_change)
  );

  // ************************************************************
  // Output registers
  // ************************************************************
  logic [7:0] a_out_reg;
  logic [7:0] a_oe_reg;
  logic [7:0] b_out_reg;
  logic [7:0] b_oe_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      a_out_reg <= `PCPM_RST_BYTE;
      a_oe_reg <= `PCPM_RST_BYTE;
      b_out_reg <= `PCPM_RST_BYTE;
      b_oe_reg <= `PCPM_RST_BYTE;
    end else begin
      a_out_reg <= a_out_next;
      a_oe_reg <= a_oe_next;
      b_out_reg <= b_out_next;
      b_oe_reg <= b_oe_next;
    end
  end

  logic [7:0] a_value_reg;
  logic [7:0] b_value_reg;
  logic [7:0] a_pull_reg;
  logic [7:0] b_pull_reg;
  logic [7:0] adc_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      a_value_reg <= `PCPM_RST_BYTE;
      b_value_reg <= `PCPM_RST_BYTE;
      a_pull_reg <= `PCPM_RST_BYTE;
      b_pull_reg <= `PCPM_RST_BYTE;
      adc_reg <= `PCPM_RST_BYTE;
    end else begin
      a_value_reg <= a_value_next;
      b_value_reg <= b_value_next;
      a_pull_reg <= a_pull_next;
      b_pull_reg <= b_pull_next;
      adc_reg <= adc_next;
    end
  end

  logic antest_reg;
  logic eamp_reg;
  logic master_reg;
  logic sync_in_reg;
  logic tmr_reg;
  logic int_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      antest_reg <= `PCPM_RST_BIT;
      eamp_reg <= `PCPM_RST_BIT;
      master_reg <= `PCPM_RST_BIT;
      sync_in_reg <= `PCPM_RST_BIT;
      tmr_reg <= `PCPM_RST_BIT;
      int_reg <= `PCPM_RST_BIT;
    end else begin
      antest_reg <= analog_test_enable;
      eamp_reg <= rif.eamp_active;
      master_reg <= rif.sync_master;
      sync_in_reg <= sync_in_next;
      tmr_reg <= tmr_next;
      int_reg <= int_next;
    end
  end

  logic scl_reg;
  logic sda_reg;
  logic pclk_reg;
  logic pdat_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_reg <= `PCPM_RST_BIT;
      sda_reg <= `PCPM_RST_BIT;
      pclk_reg <= `PCPM_RST_BIT;
      pdat_reg <= `PCPM_RST_BIT;
    end else begin
      scl_reg <= scl_next;
      sda_reg <= sda_next;
      pclk_reg <= pclk_next;
      pdat_reg <= pdat_next;
    end
  end

  assign port_a_out = a_out_reg;
  assign port_a_oe = a_oe_reg;
  assign port_b_out = b_out_reg;
  assign port_b_oe = b_oe_reg;
  assign port_a_value = a_value_reg;
  assign port_b_value = b_value_reg;
  assign port_a_pullup_on = a_pull_reg;
  assign port_b_pullup_on = b_pull_reg;
  assign adc_channel_connect = adc_reg;
  assign analog_test_out_on = antest_reg;
  assign error_amp_connect = eamp_reg;
  assign sync_master_on = master_reg;
  assign sync_clock_in = sync_in_reg;
  assign timer_zero_ext_clock = tmr_reg;
  assign external_interrupt_in = int_reg;
  assign i2c_scl_in = scl_reg;
  assign i2c_sda_in = sda_reg;
  assign serial_program_clock = pclk_reg;
  assign serial_program_data_in = pdat_reg;

endmodule : pcpm_pin_mux

// ---- verif/pcpm_pin_mux_chk.sv ----
/* Port checker of the pin mux.
   Assumes: bound to pcpm_pin_mux; outputs lag inputs by one cycle. */
`timescale 1ns/1ps
module pcpm_pin_mux_chk (
  input logic sys_clk,
  input logic rstn,
  input logic large_package,
  input logic [7:0] port_a_in,
  input logic [7:0] port_a_out,
  input logic [7:0] port_a_oe,
  input logic [7:0] port_b_out,
  input logic [7:0] port_b_oe,
  input logic [7:0] port_a_direction_reg,
  input logic [7:0] port_b_direction_reg,
  input logic [7:0] port_a_latch,
  input logic [7:0] port_a_analog_select_bit,
  input logic [7:0] port_b_analog_select_bit,
  input logic [7:0] port_a_pullup_on,
  input logic [7:0] port_b_pullup_on,
  input logic analog_test_enable,
  input logic [2:0] phase_mode_field,
  input logic alt_sync_select,
  input logic timer_zero_source_select,
  input logic external_interrupt_enable,
  input logic i2c_enable,
  input logic i2c_scl_drive_low,
  input logic i2c_sda_drive_low,
  input logic sync_clock_out,
  input logic program_mode,
  input logic [7:0] adc_channel_connect,
  input logic analog_test_out_on,
  input logic error_amp_connect,
  input logic sync_master_on,
  input logic sync_clock_in,
  input logic timer_zero_ext_clock,
  input logic external_interrupt_in,
  input logic i2c_scl_in,
  input logic serial_program_clock
);
  // ************************
  // Helper logic
  // ************************
  logic [2:0] live_reg;
  logic live, is_master, is_slave, role_on, alt_on, mst_a1, prog_small, a2_analog;
  logic [4:0] adc_exp;
  // Wait out the reset release
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      live_reg <= 3'h0;
    end else if (live_reg != 3'h4) begin
      live_reg <= live_reg + 3'h1;
    end
  end
  assign live = (live_reg == 3'h4);
  assign is_master = (phase_mode_field == 3'h1) || (phase_mode_field == 3'h3);
  assign is_slave = (phase_mode_field == 3'h2) || (phase_mode_field == 3'h4);
  assign role_on = is_master || is_slave;
  assign alt_on = large_package && alt_sync_select;
  assign mst_a1 = is_master && !alt_on;
  assign prog_small = program_mode && !large_package;
  assign a2_analog = port_a_direction_reg[2] && port_a_analog_select_bit[2];
  assign adc_exp = {port_b_direction_reg[1] & port_b_analog_select_bit[1],
    port_a_direction_reg[3:0] & port_a_analog_select_bit[3:0]};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!live);
  sequence slave_seq;
    $past(is_slave) && !$past(alt_on);
  endsequence
  // ************************
  // Assertions
  // ************************
  adc_route_a: assert property (adc_channel_connect[4:0] == $past(adc_exp))
    else $error("adc route");
  test_buf_a: assert property ($past(analog_test_enable) |->
    analog_test_out_on && !port_a_oe[0]) else $error("test buffer");
  gpio_drive_a: assert property (port_a_oe[3] == !$past(port_a_direction_reg[3]) &&
    (!port_a_oe[3] || port_a_out[3] == $past(port_a_latch[3]))) else $error("gpio drive");
  sync_role_a: assert property (sync_master_on == $past(is_master) &&
    (!$past(mst_a1) || (port_a_oe[1] && port_a_out[1] == $past(sync_clock_out))))
    else $error("sync master");
  sync_slave_a: assert property (slave_seq |->
    !port_a_oe[1] && sync_clock_in == $past(port_a_in[1])) else $error("sync slave");
  eamp_pin_a: assert property (error_amp_connect == $past(role_on) &&
    (!error_amp_connect || !port_b_oe[1])) else $error("error amp");
  timer_clk_a: assert property (!$past(a2_analog) |-> timer_zero_ext_clock ==
    ($past(timer_zero_source_select) && $past(port_a_in[2]))) else $error("timer clock");
  ext_int_a: assert property (!$past(a2_analog) |-> external_interrupt_in ==
    ($past(external_interrupt_enable) && $past(port_a_in[2]))) else $error("interrupt");
  od_pins_a: assert property (!port_a_out[4] && !port_a_out[7] && !port_b_out[0] &&
    !port_a_oe[5] && !(port_a_pullup_on[4] || port_a_pullup_on[7] || port_b_pullup_on[0]))
    else $error("pin kind");
  scl_line_a: assert property ($past(i2c_enable) && !$past(prog_small) |->
    port_a_oe[7] == $past(i2c_scl_drive_low) && i2c_scl_in == $past(port_a_in[7]))
    else $error("scl line");
  sda_line_a: assert property ($past(i2c_enable) |->
    port_b_oe[0] == $past(i2c_sda_drive_low)) else $error("sda line");
  prog_clk_a: assert property ($past(prog_small) |->
    serial_program_clock == $past(port_a_in[7]) && !port_a_oe[7]) else $error("prog clock");
  pkg_b_a: assert property (($past(large_package) |->
    port_b_oe[7:6] == ~$past(port_b_direction_reg[7:6])) and
    (!$past(large_package) |-> port_b_oe[7:4] == 4'h0)) else $error("package pins");
endmodule : pcpm_pin_mux_chk

// ---- verif/pcpm_pin_mux_bench.sv ----
/* Self-checking bench of the pin mux.
   Assumes: design and checker compiled first. */
`timescale 1ns/1ps
module pcpm_pin_mux_bench;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic large_package, analog_test_enable, alt_sync_select, timer_zero_source_select;
  logic external_interrupt_enable, i2c_enable, i2c_scl_drive_low, i2c_sda_drive_low;
  logic sync_clock_out, program_mode, program_data_out, program_data_oe;
  logic [2:0] phase_mode_field;
  logic [7:0] port_a_in, port_b_in, port_a_direction_reg, port_b_direction_reg;
  logic [7:0] port_a_latch, port_b_latch, port_a_analog_select_bit, port_b_analog_select_bit;
  logic [7:0] port_a_pullup_select, port_b_pullup_select, port_a_ioc_enable, port_b_ioc_enable;
  logic [7:0] port_a_out, port_a_oe, port_b_out, port_b_oe, port_a_value, port_b_value;
  logic [7:0] port_a_pullup_on, port_b_pullup_on, port_a_change, port_b_change;
  logic [7:0] adc_channel_connect, m;
  logic analog_test_out_on, error_amp_connect, sync_master_on, sync_clock_in;
  logic timer_zero_ext_clock, external_interrupt_in, i2c_scl_in, i2c_sda_in;
  logic serial_program_clock, serial_program_data_in;
  logic [15:0] seed = 16'h0003;
  int fail_count = 0;
  int tests_run = 0;

  pcpm_pin_mux u_dut (.*);

  always #10 sys_clk = ~sys_clk;

  // ************************
  // Helpers
  // ************************
  function automatic logic [15:0] lfsr();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction : lfsr

  function automatic logic [7:0] exp_oe(input logic [7:0] c, o, l, d);
    return (c | (~l & o)) & ~d;
  endfunction : exp_oe

  function automatic logic [7:0] exp_adc();
    logic [7:0] d;
    d = port_b_direction_reg & port_b_analog_select_bit;
    return {large_package & d[5], large_package & d[4], d[2:1],
      port_a_direction_reg[3:0] & port_a_analog_select_bit[3:0]};
  endfunction : exp_adc

  function automatic logic [7:0] exp_role(input logic [2:0] k);
    logic mst, act;
    mst = (k == 3'h1) || (k == 3'h3);
    act = (k >= 3'h1) && (k <= 3'h4);
    return {3'h0, mst, act, act ? mst : 1'b1, !act, !act};
  endfunction : exp_role

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick;
    @(posedge sys_clk);
  endtask : tick

  task automatic look;
    @(posedge sys_clk);
    #1;
  endtask : look

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // ************************
  // Sequence
  // ************************
  initial begin
    {large_package, analog_test_enable, alt_sync_select, timer_zero_source_select,
      external_interrupt_enable, i2c_enable, i2c_scl_drive_low, i2c_sda_drive_low,
      sync_clock_out, program_mode, program_data_out, program_data_oe} = 12'h000;
    phase_mode_field = 3'h0;
    {port_a_in, port_b_in, port_a_direction_reg, port_b_direction_reg, port_b_latch,
      port_a_analog_select_bit, port_b_analog_select_bit, port_a_pullup_select,
      port_b_pullup_select, port_a_ioc_enable, port_b_ioc_enable} = '0;
    port_a_latch = 8'hFF;
    repeat (8) tick;
    look;
    chk(port_a_oe, 8'h00);
    chk(adc_channel_connect, 8'h00);
    repeat (7) tick;
    rstn <= 1'b1;
    repeat (3) tick;
    $display("reset test done");
    for (int k = 0; k < 8; k++) begin
      tick;
      phase_mode_field <= 3'(k);
      look;
      chk({3'h0, sync_master_on, error_amp_connect, port_a_oe[1], port_a_out[1] & port_a_oe[1],
        port_b_oe[1]}, exp_role(3'(k)));
    end
    $display("phase mode test done");
    tick;
    phase_mode_field <= 3'h0;
    {port_a_in, port_b_in, port_a_latch} <= 24'hFFFF00;
    {analog_test_enable, timer_zero_source_select, external_interrupt_enable} <= 3'h7;
    {i2c_enable, i2c_sda_drive_low} <= 2'h3;
    look;
    chk({analog_test_out_on, port_a_oe[0], timer_zero_ext_clock, external_interrupt_in,
      i2c_scl_in, i2c_sda_in, port_a_oe[7], port_b_oe[0]}, 8'hBD);
    tick;
    {program_mode, program_data_oe, program_data_out, i2c_scl_drive_low} <= 4'hF;
    look;
    chk({4'h0, serial_program_data_in, serial_program_clock, port_a_oe[7], port_a_out[6]},
      8'h0D);
    tick;
    {large_package, alt_sync_select, sync_clock_out} <= 3'h7;
    phase_mode_field <= 3'h1;
    look;
    chk({5'h00, serial_program_data_in, serial_program_clock, port_b_oe[5]}, 8'h06);
    tick;
    program_mode <= 1'b0;
    look;
    chk({4'h0, port_b_oe[5], port_b_out[5], port_a_oe[1], port_a_out[1]}, 8'h0E);
    $display("peripheral test done");
    tick;
    {analog_test_enable, alt_sync_select, timer_zero_source_select} <= 3'h0;
    {external_interrupt_enable, i2c_enable, program_mode, phase_mode_field} <= 6'h00;
    {port_a_direction_reg, port_b_direction_reg, port_a_pullup_select} <= 24'hFFFFFF;
    {port_b_pullup_select, port_a_ioc_enable, port_b_ioc_enable} <= 24'hFFF7FF;
    {port_a_in, port_b_in} <= 16'h0000;
    look;
    chk(port_a_change, 8'hF7);
    chk(port_b_change, 8'hF7);
    chk(port_a_pullup_on, 8'h2F);
    chk(port_b_pullup_on, 8'hF6);
    tick;
    {port_a_in, port_b_in} <= 16'hFFFF; // Includes input-only pin
    look;
    chk(port_a_change, 8'hF7);
    look;
    chk(port_a_change, 8'h00);
    $display("change test done");
    for (int k = 0; k < 200; k++) begin
      tick;
      {port_a_direction_reg, port_a_latch} <= lfsr();
      {port_b_direction_reg, port_b_latch} <= lfsr();
      {port_a_analog_select_bit, port_b_analog_select_bit} <= lfsr();
      {port_a_in, port_b_in} <= lfsr();
      {port_a_pullup_select, port_b_pullup_select} <= lfsr();
      {port_a_ioc_enable, port_b_ioc_enable} <= lfsr();
      large_package <= seed[3];
      if (k >= 100) begin
        {analog_test_enable, alt_sync_select, timer_zero_source_select, external_interrupt_enable,
          i2c_enable, i2c_scl_drive_low, i2c_sda_drive_low, sync_clock_out, program_mode,
          program_data_out, program_data_oe, phase_mode_field} <= 14'(lfsr());
      end
      look;
      chk(adc_channel_connect, exp_adc());
      chk(port_b_value, port_b_in & ~(port_b_direction_reg & port_b_analog_select_bit & 8'h36) &
        (large_package ? 8'hF7 : 8'h07));
      if (k < 100) begin
        m = ~port_a_direction_reg & 8'hDF;
        chk(port_a_oe, exp_oe(8'h4F, 8'h90, port_a_latch, port_a_direction_reg));
        chk(port_b_oe, exp_oe(large_package ? 8'hF6 : 8'h06, 8'h01, port_b_latch,
          port_b_direction_reg));
        chk(port_a_out & m, port_a_latch & m & 8'h4F);
        chk(port_a_value, port_a_in & ~(port_a_direction_reg & port_a_analog_select_bit &
          8'h0F));
      end
    end
    $display("random test done");
    final_report;
  end

  initial begin
    repeat (2000) tick;
    fail_count++;
    final_report;
  end
endmodule : pcpm_pin_mux_bench

bind pcpm_pin_mux pcpm_pin_mux_chk u_chk (.*);
